// ### logic/pgf_consts.svh
`ifndef PGF_CONSTS_SVH
`define PGF_CONSTS_SVH

// Register offsets
`define PGF_ADDR_STATUS 8'h10
`define PGF_ADDR_MASK 8'h11
`define PGF_ADDR_CTRL 8'h12
`define PGF_ADDR_VREF 8'h13
`define PGF_ADDR_RAMP 8'h14
`define PGF_ADDR_VREF_EFF 8'h15

// Status and mask bit positions
`define PGF_BIT_OVP 0
`define PGF_BIT_HSHORT 1
`define PGF_BIT_THERM 2
`define PGF_BIT_OCP 3
`define PGF_BIT_PG 4

// Control register fields
`define PGF_CTRL_FREQ_LSB 0
`define PGF_CTRL_SLEW_LSB 2

// Reset values
`define PGF_MASK_RST 5'h0f
`define PGF_FREQ_RST 2'h0
`define PGF_SLEW_RST 2'h0
`define PGF_VREF_RST 8'h07

// Frequency codes: 1.8, 1.5, 1.2 MHz; 2'h3 is not a legal setting
`define PGF_FREQ_1M8 2'h0
`define PGF_FREQ_1M5 2'h1
`define PGF_FREQ_1M2 2'h2
`define PGF_FREQ_BAD 2'h3

// Switch phase codes from the modulator
`define PGF_PHASE_IDLE 2'h0
`define PGF_PHASE_1 2'h1
`define PGF_PHASE_2 2'h2
`define PGF_PHASE_3 2'h3

// Reference scaling
`define PGF_VREF_CODE_MAX 8'h8f
`define PGF_VREF_BASE_UV 20'd299000
`define PGF_VREF_STEP_UV 20'd4900
`define PGF_VOUT_GAIN 24'd15

// Timing
`define PGF_CLK_MHZ 25
`define PGF_SS_TIME_US 2000
`define PGF_SLEW_STEP_NS 3675

`endif

// ### logic/pgf_pkg.sv
`default_nettype none
package pgf_pkg;
	typedef enum logic [2:0] {
		ST_OFF,
		ST_DISCHARGE,
		ST_SOFTSTART,
		ST_RUN,
		ST_LATCHED
	} pgf_state_t;
endpackage
`default_nettype wire

// ### logic/pgf_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pgf_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Asynchronous inputs and their synchronised copies
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// Runs without the clock enable so pins are never sampled stale
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;
endmodule
`default_nettype wire

// ### logic/pgf_vref_ramp.sv
`timescale 1ns/1ps
`default_nettype none
`include "pgf_consts.svh"
module pgf_vref_ramp #(
	parameter int STEP_CYCLES = 92
) (
	// Clock, clear and enable
	input wire logic clk,
	input wire logic clr_n,
	input wire logic ce,
	// Target and rate
	input wire logic [7:0] target,
	input wire logic [1:0] slew,
	// Effective code and ramp flag
	output logic [7:0] code_q,
	output logic busy
);
	logic [15:0] cnt_q;
	logic [15:0] interval;

	// Each slew step doubles the rate; never below one cycle per step
	always_comb begin
		interval = 16'(STEP_CYCLES) >> slew;
		if (interval == 16'h0000) begin
			interval = 16'h0001;
		end
	end

	assign busy = (code_q != target);

	always_ff @(posedge clk) begin
		if (!clr_n) begin
			code_q <= `PGF_VREF_RST;
			cnt_q <= 16'h0000;
		end else if (ce) begin
			if (!busy) begin
				cnt_q <= 16'h0000;
			end else if (cnt_q >= interval - 16'h0001) begin
				cnt_q <= 16'h0000;
				if (code_q < target) begin
					code_q <= code_q + 8'h01;
				end else begin
					code_q <= code_q - 8'h01;
				end
			end else begin
				cnt_q <= cnt_q + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

// ### logic/pgf_power_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
`include "pgf_consts.svh"
module pgf_power_supervisor #(
	parameter int SS_CYCLES = `PGF_SS_TIME_US * `PGF_CLK_MHZ,
	parameter int STEP_CYCLES = ((`PGF_SLEW_STEP_NS * `PGF_CLK_MHZ) + 999) / 1000
) (
	// Clock, reset and enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Enable pin and analog comparators
	input wire logic en_pin,
	input wire logic vout_under_low,
	input wire logic vout_over_high,
	input wire logic vout_above_discharge,
	// Fault detectors
	input wire logic ovp_event,
	input wire logic hardshort_event,
	input wire logic thermal_event,
	input wire logic ocp_event,
	// Modulator phase request
	input wire logic [1:0] pwm_phase,
	// Open-drain status alert pin
	input wire logic status_alert_pin_n_i,
	output logic status_alert_pin_n_o,
	output logic status_alert_pin_n_oe,
	// H-bridge switch enables
	output logic input_high_side_switch,
	output logic output_high_side_switch,
	output logic input_low_side_switch,
	output logic output_low_side_switch,
	// Regulator status and settings
	output logic output_discharge,
	output logic regulator_on,
	output logic soft_start_active,
	output logic dynamic_voltage_ramp,
	output logic [1:0] switch_rate_select,
	output logic [19:0] vref_uv,
	output logic [23:0] vout_target_uv
);
	localparam int NSYNC = 11;

	logic [NSYNC-1:0] sync_in;
	logic [NSYNC-1:0] sync_out;
	logic en_s;
	logic under_s;
	logic over_s;
	logic above_dis_s;
	logic ovp_s;
	logic hshort_s;
	logic therm_s;
	logic ocp_s;
	logic [1:0] phase_s;
	logic pin_level_s;
	logic clr_n;

	assign sync_in = {pwm_phase, status_alert_pin_n_i, ocp_event, thermal_event,
		hardshort_event, ovp_event, vout_above_discharge, vout_over_high,
		vout_under_low, en_pin};

	pgf_sync #(
		.W(NSYNC)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.async_i(sync_in),
		.sync_o(sync_out)
	);

	assign en_s = sync_out[0];
	assign under_s = sync_out[1];
	assign over_s = sync_out[2];
	assign above_dis_s = sync_out[3];
	assign ovp_s = sync_out[4];
	assign hshort_s = sync_out[5];
	assign therm_s = sync_out[6];
	assign ocp_s = sync_out[7];
	assign pin_level_s = sync_out[8];
	assign phase_s = sync_out[10:9];

	// Enable low acts as a register reset, like cycling the supply
	assign clr_n = rst_n & en_s;

	// Register state
	logic [4:0] mask_q;
	logic [1:0] freq_q;
	logic [1:0] slew_q;
	logic [7:0] vref_q;
	logic [3:0] fault_q;
	logic pg_q;
	logic [7:0] rdata_q;

	pgf_pkg::pgf_state_t state_q;
	logic [15:0] ss_cnt_q;
	logic [7:0] vref_eff;
	logic ramp_busy;

	function automatic logic [19:0] code_to_uv(input logic [7:0] code);
		code_to_uv = 20'(`PGF_VREF_BASE_UV + 20'(code) * `PGF_VREF_STEP_UV);
	endfunction

	function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] target);
		wr_hit = (addr == target);
	endfunction

	// Mask register
	always_ff @(posedge clk) begin
		if (!clr_n) begin
			mask_q <= `PGF_MASK_RST;
		end else if (ce && reg_wr && wr_hit(reg_addr, `PGF_ADDR_MASK)) begin
			mask_q <= reg_wdata[4:0];
		end
	end

	// Frequency and slew control; an illegal frequency code is ignored
	always_ff @(posedge clk) begin
		if (!clr_n) begin
			freq_q <= `PGF_FREQ_RST;
			slew_q <= `PGF_SLEW_RST;
		end else if (ce && reg_wr && wr_hit(reg_addr, `PGF_ADDR_CTRL)) begin
			if (reg_wdata[`PGF_CTRL_FREQ_LSB +: 2] != `PGF_FREQ_BAD) begin
				freq_q <= reg_wdata[`PGF_CTRL_FREQ_LSB +: 2];
			end
			slew_q <= reg_wdata[`PGF_CTRL_SLEW_LSB +: 2];
		end
	end

	// Reference target; codes past 1 V are clamped to the top code
	always_ff @(posedge clk) begin
		if (!clr_n) begin
			vref_q <= `PGF_VREF_RST;
		end else if (ce && reg_wr && wr_hit(reg_addr, `PGF_ADDR_VREF)) begin
			if (reg_wdata > `PGF_VREF_CODE_MAX) begin
				vref_q <= `PGF_VREF_CODE_MAX;
			end else begin
				vref_q <= reg_wdata;
			end
		end
	end

	pgf_vref_ramp #(
		.STEP_CYCLES(STEP_CYCLES)
	) u_ramp (
		.clk(clk),
		.clr_n(clr_n),
		.ce(ce),
		.target(vref_q),
		.slew(slew_q),
		.code_q(vref_eff),
		.busy(ramp_busy)
	);

	// Regulator sequencing
	always_ff @(posedge clk) begin
		if (!clr_n) begin
			state_q <= pgf_pkg::ST_OFF;
			ss_cnt_q <= 16'h0000;
		end else if (ce) begin
			case (state_q)
				pgf_pkg::ST_OFF: begin
					ss_cnt_q <= 16'h0000;
					if (above_dis_s) begin
						state_q <= pgf_pkg::ST_DISCHARGE;
					end else begin
						state_q <= pgf_pkg::ST_SOFTSTART;
					end
				end
				pgf_pkg::ST_DISCHARGE: begin
					// Pre-biased output is drained before soft-start
					if (!above_dis_s) begin
						state_q <= pgf_pkg::ST_SOFTSTART;
					end
				end
				pgf_pkg::ST_SOFTSTART: begin
					if (fault_q[`PGF_BIT_THERM] || fault_q[`PGF_BIT_OCP]) begin
						state_q <= pgf_pkg::ST_LATCHED;
					end else if (ss_cnt_q >= 16'(SS_CYCLES - 1)) begin
						state_q <= pgf_pkg::ST_RUN;
					end else begin
						ss_cnt_q <= ss_cnt_q + 16'h0001;
					end
				end
				pgf_pkg::ST_RUN: begin
					if (fault_q[`PGF_BIT_HSHORT] || fault_q[`PGF_BIT_THERM] ||
						fault_q[`PGF_BIT_OCP]) begin
						state_q <= pgf_pkg::ST_LATCHED;
					end
				end
				pgf_pkg::ST_LATCHED: begin
					// Only an enable or supply cycle leaves this state
					state_q <= pgf_pkg::ST_LATCHED;
				end
				default: begin
					state_q <= pgf_pkg::ST_OFF;
				end
			endcase
		end
	end

	// Sticky fault flags, cleared only by clr_n
	always_ff @(posedge clk) begin
		if (!clr_n) begin
			fault_q <= 4'h0;
		end else if (ce) begin
			if (ovp_s) begin
				fault_q[`PGF_BIT_OVP] <= 1'b1;
			end
			// Hardshort detection is blind during soft-start
			if (hshort_s && state_q == pgf_pkg::ST_RUN) begin
				fault_q[`PGF_BIT_HSHORT] <= 1'b1;
			end
			if (therm_s) begin
				fault_q[`PGF_BIT_THERM] <= 1'b1;
			end
			if (ocp_s) begin
				fault_q[`PGF_BIT_OCP] <= 1'b1;
			end
		end
	end

	// Power-good with hysteresis, frozen during soft-start and ramps
	always_ff @(posedge clk) begin
		if (!clr_n) begin
			pg_q <= 1'b0;
		end else if (ce && state_q == pgf_pkg::ST_RUN && !ramp_busy) begin
			if (under_s) begin
				pg_q <= 1'b0;
			end else if (over_s) begin
				pg_q <= 1'b1;
			end
		end
	end

	// Alert pin: pulled low while any unmasked flag is set
	always_ff @(posedge clk) begin
		if (!clr_n) begin
			status_alert_pin_n_oe <= 1'b0;
		end else if (ce) begin
			status_alert_pin_n_oe <= |({pg_q, fault_q} & ~mask_q);
		end
	end

	assign status_alert_pin_n_o = 1'b0;

	// Switch decode; overvoltage forces both low sides on in soft-start and run, all switches stay off in other states
	always_ff @(posedge clk) begin
		if (!clr_n) begin
			input_high_side_switch <= 1'b0;
			output_high_side_switch <= 1'b0;
			input_low_side_switch <= 1'b0;
			output_low_side_switch <= 1'b0;
		end else if (ce) begin
			input_high_side_switch <= 1'b0;
			output_high_side_switch <= 1'b0;
			input_low_side_switch <= 1'b0;
			output_low_side_switch <= 1'b0;
			if (state_q == pgf_pkg::ST_SOFTSTART || state_q == pgf_pkg::ST_RUN) begin
				if (ovp_s) begin
					input_low_side_switch <= 1'b1;
					output_low_side_switch <= 1'b1;
				end else begin
					case (phase_s)
						`PGF_PHASE_1: begin
							input_high_side_switch <= 1'b1;
							output_low_side_switch <= 1'b1;
						end
						`PGF_PHASE_2: begin
							input_high_side_switch <= 1'b1;
							output_high_side_switch <= 1'b1;
						end
						`PGF_PHASE_3: begin
							input_low_side_switch <= 1'b1;
							output_high_side_switch <= 1'b1;
						end
						default: begin
							input_low_side_switch <= 1'b0;
						end
					endcase
				end
			end
		end
	end

	// Regulator status outputs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			output_discharge <= 1'b1;
			regulator_on <= 1'b0;
			soft_start_active <= 1'b0;
		end else if (ce) begin
			// Thermal latch-off leaves the discharge switch open
			output_discharge <= !en_s || state_q == pgf_pkg::ST_OFF ||
				state_q == pgf_pkg::ST_DISCHARGE ||
				(state_q == pgf_pkg::ST_LATCHED && !fault_q[`PGF_BIT_THERM]);
			regulator_on <= en_s && (state_q == pgf_pkg::ST_SOFTSTART ||
				state_q == pgf_pkg::ST_RUN);
			soft_start_active <= en_s && state_q == pgf_pkg::ST_SOFTSTART;
		end
	end

	// Setting and reference outputs
	always_ff @(posedge clk) begin
		if (!clr_n) begin
			switch_rate_select <= `PGF_FREQ_RST;
			dynamic_voltage_ramp <= 1'b0;
			vref_uv <= code_to_uv(`PGF_VREF_RST);
			vout_target_uv <= 24'(code_to_uv(`PGF_VREF_RST)) * `PGF_VOUT_GAIN;
		end else if (ce) begin
			switch_rate_select <= freq_q;
			dynamic_voltage_ramp <= ramp_busy;
			vref_uv <= code_to_uv(vref_eff);
			vout_target_uv <= 24'(code_to_uv(vref_eff)) * `PGF_VOUT_GAIN;
		end
	end

	// Read port: data only in the cycle after the strobe, zero elsewhere
	always_ff @(posedge clk) begin
		if (!clr_n) begin
			rdata_q <= 8'h00;
		end else if (ce) begin
			rdata_q <= 8'h00;
			if (reg_rd) begin
				case (reg_addr)
					`PGF_ADDR_STATUS: rdata_q <= {3'h0, pg_q, fault_q};
					`PGF_ADDR_MASK: rdata_q <= {3'h0, mask_q};
					`PGF_ADDR_CTRL: rdata_q <= {4'h0, slew_q, freq_q};
					`PGF_ADDR_VREF: rdata_q <= vref_q;
					`PGF_ADDR_RAMP: rdata_q <= {ramp_busy, pin_level_s, regulator_on,
						output_discharge, 4'h0};
					`PGF_ADDR_VREF_EFF: rdata_q <= vref_eff;
					default: rdata_q <= 8'h00;
				endcase
			end
		end
	end

	assign reg_rdata = rdata_q;
endmodule
`default_nettype wire

// ### dv/pgf_props.sv
`timescale 1ns/1ps
`default_nettype none
module pgf_props (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Watched ports
	input wire logic en_pin,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic status_alert_pin_n_o,
	input wire logic status_alert_pin_n_oe,
	input wire logic input_high_side_switch,
	input wire logic output_high_side_switch,
	input wire logic input_low_side_switch,
	input wire logic output_low_side_switch,
	input wire logic output_discharge,
	input wire logic regulator_on,
	input wire logic dynamic_voltage_ramp,
	input wire logic [1:0] switch_rate_select,
	input wire logic [19:0] vref_uv,
	input wire logic [23:0] vout_target_uv
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_vref_settled;
		$stable(vref_uv) [*2];
	endsequence
	// Six low samples cover the two-stage synchroniser and the register reset
	sequence s_enable_low;
		!en_pin [*6];
	endsequence
	a_read_idle: assert property (
		!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside answer cycle");
	a_target_gain: assert property (
		s_vref_settled |-> vout_target_uv == 24'(vref_uv) * 24'd15) else $error("target not 15x");
	a_no_shoot_in: assert property (
		!(input_high_side_switch && input_low_side_switch)) else $error("input leg shorted");
	a_no_shoot_out: assert property (
		!(output_high_side_switch && output_low_side_switch)) else $error("output leg shorted");
	a_enable_reset: assert property (
		s_enable_low |-> output_discharge && !regulator_on && !status_alert_pin_n_oe
		&& switch_rate_select == 2'h0 && vref_uv == 20'd333300) else $error("enable low state");
	a_pin_drive: assert property (
		status_alert_pin_n_o == 1'b0) else $error("alert pin driven high");
	a_ramp_hold: assert property (
		(!dynamic_voltage_ramp && en_pin) [*4] |-> $stable(vref_uv)) else $error("ref moved idle");
	a_ramp_step: assert property (
		$changed(vref_uv) && $past(dynamic_voltage_ramp) && en_pin |->
		vref_uv - $past(vref_uv) == 20'd4900 || $past(vref_uv) - vref_uv == 20'd4900)
		else $error("ramp step size");
	c_ramp: cover property (dynamic_voltage_ramp);
endmodule
bind pgf_power_supervisor pgf_props u_props (.clk(clk), .rst_n(rst_n), .en_pin(en_pin),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .status_alert_pin_n_o(status_alert_pin_n_o),
	.status_alert_pin_n_oe(status_alert_pin_n_oe),
	.input_high_side_switch(input_high_side_switch),
	.output_high_side_switch(output_high_side_switch),
	.input_low_side_switch(input_low_side_switch),
	.output_low_side_switch(output_low_side_switch), .output_discharge(output_discharge),
	.regulator_on(regulator_on), .dynamic_voltage_ramp(dynamic_voltage_ramp),
	.switch_rate_select(switch_rate_select), .vref_uv(vref_uv),
	.vout_target_uv(vout_target_uv));
`default_nettype wire

// ### dv/pgf_host.sv
`timescale 1ns/1ps
`default_nettype none
module pgf_host (
	// Clock
	input wire logic clk,
	// Register port
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// Idle bus shows inverted values so a stale address can never pass for a live one
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= wr;
		reg_rd <= !wr;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	task automatic alert_on_faults();
		access(1'b1, 8'h11, 8'h10);
	endtask
endmodule
`default_nettype wire

// ### dv/pgf_power_supervisor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pgf_power_supervisor_tb;
	logic clk;
	logic rst_n;
	logic en_pin;
	logic under;
	logic over;
	logic [3:0] fault_ev;
	logic [1:0] pwm_phase;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic alert_oe;
	logic [3:0] sw;
	logic dis;
	logic reg_on;
	logic soft_start;
	logic ramp;
	logic [1:0] rate;
	logic [19:0] vref_uv;
	logic [23:0] vout_target_uv;
	logic rd_seen = 1'b0;
	logic [7:0] exp_q[$];
	logic [7:0] e_mon;
	logic [7:0] tgt;
	logic [1:0] slew;
	logic [3:0] phase_sw [4];
	int n_mismatch;
	int checks;

	pgf_host host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd));

	pgf_power_supervisor #(.SS_CYCLES(20), .STEP_CYCLES(8)) dut (.clk(clk), .rst_n(rst_n),
		.ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .en_pin(en_pin), .vout_under_low(under),
		.vout_over_high(over), .vout_above_discharge(1'b0), .ovp_event(fault_ev[0]),
		.hardshort_event(fault_ev[1]), .thermal_event(fault_ev[2]), .ocp_event(fault_ev[3]),
		.pwm_phase(pwm_phase), .status_alert_pin_n_i(!alert_oe), .status_alert_pin_n_o(),
		.status_alert_pin_n_oe(alert_oe), .input_high_side_switch(sw[3]),
		.output_high_side_switch(sw[2]), .input_low_side_switch(sw[1]),
		.output_low_side_switch(sw[0]), .output_discharge(dis), .regulator_on(reg_on),
		.soft_start_active(soft_start), .dynamic_voltage_ramp(ramp),
		.switch_rate_select(rate), .vref_uv(vref_uv), .vout_target_uv(vout_target_uv));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic end_of_test();
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic fail(input string msg);
		n_mismatch++;
		$display("[FAIL] %0t %s", $time, msg);
	endtask
	// Callers sample on the falling edge so registered outputs have settled
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checks++;
		if (got !== exp) begin
			fail($sformatf("got %h want %h", got, exp));
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.access(1'b0, a, 8'h00);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.access(1'b1, a, d);
	endtask
	task automatic wait_lvl(input bit sel, input logic v);
		for (int i = 0; i < 300; i++) begin
			#1;
			if ((sel ? ramp : soft_start) === v) begin
				return;
			end
			@(posedge clk);
		end
		fail("wait bound used up");
		end_of_test();
	endtask
	task automatic drive(input logic u, input logic o);
		@(posedge clk);
		under <= u;
		over <= o;
		repeat (4) @(posedge clk);
	endtask
	task automatic power_up();
		@(posedge clk);
		en_pin <= 1'b1;
		wait_lvl(1'b0, 1'b1);
		rd(8'h10, 8'h00);
		wait_lvl(1'b0, 1'b0);
		repeat (3) @(posedge clk);
	endtask

	// Read data stands only in the cycle after the strobe
	always @(posedge clk) begin
		if (rd_seen) begin
			checks++;
			e_mon = exp_q.pop_front();
			if (reg_rdata !== e_mon) begin
				fail($sformatf("read %h want %h", reg_rdata, e_mon));
			end
		end
		rd_seen <= reg_rd;
	end

	initial begin
		repeat (20000) @(posedge clk);
		fail("run too long");
		end_of_test();
	end

	initial begin
		rst_n = 1'b0;
		en_pin = 1'b0;
		under = 1'b0;
		over = 1'b1;
		fault_ev = 4'h0;
		pwm_phase = 2'h0;
		n_mismatch = 0;
		checks = 0;
		phase_sw = '{4'h0, 4'h9, 4'hc, 4'h6};
		void'($urandom(38));
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		// Registers are held in reset while enable is low, so reset values are read after power-up
		power_up();
		rd(8'h11, 8'h0f);
		rd(8'h12, 8'h00);
		rd(8'h13, 8'h07);
		rd(8'h20, 8'h00);
		rd(8'h10, 8'h10);
		@(negedge clk);
		chk(vout_target_uv, 24'd4999500);
		chk({23'h0, alert_oe}, 24'h1);
		drive(1'b0, 1'b0);
		rd(8'h10, 8'h10);
		drive(1'b1, 1'b0);
		rd(8'h10, 8'h00);
		@(negedge clk);
		chk({23'h0, alert_oe}, 24'h0);
		drive(1'b0, 1'b1);
		rd(8'h10, 8'h10);
		for (int i = 0; i < 4; i++) begin
			wr(8'h12, 8'(i));
			rd(8'h12, i == 3 ? 8'h02 : 8'(i));
		end
		@(negedge clk);
		chk({22'h0, rate}, 24'h2);
		for (int i = 1; i < 4; i++) begin
			@(posedge clk);
			pwm_phase <= 2'(i);
			repeat (4) @(posedge clk);
			@(negedge clk);
			chk({20'h0, sw}, {20'h0, phase_sw[i]});
		end
		@(posedge clk);
		pwm_phase <= 2'h0;
		// Slow slews only: the power-good freeze check needs the ramp to outlast the read
		slew = 2'($urandom % 2);
		tgt = 8'h0b + 8'($urandom % 4);
		wr(8'h12, {4'h0, slew, 2'h0});
		wr(8'h13, tgt);
		wait_lvl(1'b1, 1'b1);
		drive(1'b1, 1'b0);
		rd(8'h10, 8'h10);
		wait_lvl(1'b1, 1'b0);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk({4'h0, vref_uv}, 24'd299000 + 24'(tgt) * 24'd4900);
		chk(vout_target_uv, (24'd299000 + 24'(tgt) * 24'd4900) * 24'd15);
		rd(8'h15, tgt);
		rd(8'h10, 8'h00);
		rd(8'h12, {4'h0, slew, 2'h0});
		drive(1'b0, 1'b1);
		// Fastest slew, with a code past the top that must clamp at 1 V
		wr(8'h12, 8'h0c);
		wr(8'h13, 8'hff);
		wait_lvl(1'b1, 1'b1);
		wait_lvl(1'b1, 1'b0);
		rd(8'h13, 8'h8f);
		rd(8'h15, 8'h8f);
		@(negedge clk);
		chk({4'h0, vref_uv}, 24'd299000 + 24'd143 * 24'd4900);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			en_pin <= 1'b0;
			repeat (6) @(posedge clk);
			power_up();
			host.alert_on_faults();
			@(posedge clk);
			fault_ev <= 4'(1 << i);
			repeat (4) @(posedge clk);
			fault_ev <= 4'h0;
			repeat (3) @(posedge clk);
			rd(8'h10, 8'h10 | 8'(1 << i));
			@(negedge clk);
			chk({23'h0, alert_oe}, 24'h1);
			wr(8'h10, 8'h00);
			wr(8'h11, 8'h1f);
			repeat (2) @(posedge clk);
			@(negedge clk);
			chk({23'h0, alert_oe}, 24'h0);
			rd(8'h10, 8'h10 | 8'(1 << i));
		end
		@(posedge clk);
		en_pin <= 1'b0;
		repeat (6) @(posedge clk);
		@(negedge clk);
		chk({22'h0, dis, reg_on}, 24'h2);
		power_up();
		rd(8'h11, 8'h0f);
		rd(8'h10, 8'h10);
		@(negedge clk);
		chk({23'h0, alert_oe}, 24'h1);
		repeat (2) @(posedge clk);
		end_of_test();
	end
endmodule
`default_nettype wire
